// [design/caas_alu.sv]
// execution datapath for pointer add, and, add, shift and bit clear ops
// Behaviour
// RULE_01 - pointer add: sign-extended literal, flags unchanged
// RULE_02 - pointer sum wraps modulo 2^16
// RULE_03 - and literal into accumulator, zero flag only
// RULE_04 - add literal into accumulator, C DC Z
// RULE_05 - and accumulator with file, zero flag only
// RULE_06 - add accumulator and file, C DC Z
// RULE_07 - destination bit picks accumulator or file
// RULE_08 - shift right keeps sign bit
// RULE_09 - shift loads carry from bit 0, Z
// RULE_10 - add with carry updates C DC Z
// RULE_11 - add with carry may write file
// RULE_12 - bit clear touches one bit, no flags
// RULE_13 - Z on zero result, carries from bits 7/3
module caas_alu #(
    parameter int DEPTH = 128 // file register count
) (
    input wire logic core_clk_in, // instruction clock
    input wire logic rst_b_in, // async reset, active low
    input wire logic exec_in, // one-cycle execute strobe
    input wire caas_pkg::caas_op_t op_in, // operation select
    input wire logic [7:0] literal_in, // 8-bit immediate
    input wire logic [5:0] ptr_lit_in, // signed 6-bit pointer literal
    input wire logic ptr_sel_in, // pointer 0 or 1
    input wire logic [6:0] file_addr_in, // file register address
    input wire logic dest_in, // 0 accumulator, 1 file
    input wire logic [2:0] bit_idx_in, // bit index for clear
    output logic [7:0] acc_out, // working register
    output logic [15:0] pointer0_out, // indirect pointer 0
    output logic [15:0] pointer1_out, // indirect pointer 1
    output logic carry_flag_out, // carry flag
    output logic digit_carry_flag_out, // digit carry flag
    output logic zero_flag_out, // zero flag
    output logic [7:0] file_rd_out // file register at file_addr, registered
);
    logic [7:0] acc; // accumulator
    logic [15:0] ptr [2]; // pointer pairs
    logic [7:0] mem [DEPTH]; // file registers
    logic carry; // carry flag
    logic dcarry; // digit carry flag
    logic zero; // zero flag
    logic [7:0] file_rd; // registered read of addressed file register
    logic [7:0] fval; // current value of addressed file
    logic [7:0] add_b; // adder second operand
    logic add_c; // adder carry in
    logic [7:0] add_sum; // adder result
    logic add_co; // adder carry out
    logic add_dc; // adder digit carry
    logic [7:0] next_result; // result of the op
    logic next_wr_file; // result goes to file
    logic next_wr_acc; // result goes to accumulator
    logic upd_z; // op updates zero
    logic upd_c; // op updates carry
    logic upd_dc; // op updates digit carry
    logic [7:0] next_carry_src; // shift carry source holder
    logic [15:0] next_ptr; // pointer sum

    assign fval = mem[file_addr_in];

    // second adder operand and carry in depend on the op
    always_comb begin
        add_b = fval;
        add_c = 1'b0;
        if (op_in == caas_pkg::CAAS_OP_ADD_LIT) begin
            add_b = literal_in;
        end
        if (op_in == caas_pkg::CAAS_OP_ADD_FILE_C) begin
            add_c = carry; // RULE_10
        end
    end

    caas_adder u_adder (
        .a_in(acc),
        .b_in(add_b),
        .c_in(add_c),
        .sum_out(add_sum),
        .c_out(add_co),
        .dc_out(add_dc)
    );

    // sign-extend literal; 16-bit sum drops overflow so it wraps
    assign next_ptr = ptr[ptr_sel_in] + {{10{ptr_lit_in[5]}}, ptr_lit_in}; // RULE_01 RULE_02

    // result, destination and flag-update selection per op
    always_comb begin
        next_result = 8'h00;
        next_wr_file = 1'b0;
        next_wr_acc = 1'b0;
        upd_z = 1'b0;
        upd_c = 1'b0;
        upd_dc = 1'b0;
        next_carry_src = 8'h00;
        case (op_in)
            caas_pkg::CAAS_OP_AND_LIT: begin
                next_result = acc & literal_in; // RULE_03
                next_wr_acc = 1'b1;
                upd_z = 1'b1;
            end
            caas_pkg::CAAS_OP_ADD_LIT: begin
                next_result = add_sum; // RULE_04
                next_wr_acc = 1'b1;
                upd_z = 1'b1;
                upd_c = 1'b1;
                upd_dc = 1'b1;
            end
            caas_pkg::CAAS_OP_AND_FILE: begin
                next_result = acc & fval; // RULE_05
                next_wr_file = (dest_in == caas_pkg::DEST_FILE); // RULE_07
                next_wr_acc = (dest_in == caas_pkg::DEST_ACC); // RULE_07
                upd_z = 1'b1;
            end
            caas_pkg::CAAS_OP_ADD_FILE, caas_pkg::CAAS_OP_ADD_FILE_C: begin
                next_result = add_sum; // RULE_06 RULE_10
                next_wr_file = (dest_in == caas_pkg::DEST_FILE); // RULE_07 RULE_11
                next_wr_acc = (dest_in == caas_pkg::DEST_ACC); // RULE_07
                upd_z = 1'b1;
                upd_c = 1'b1;
                upd_dc = 1'b1;
            end
            caas_pkg::CAAS_OP_ASR_FILE: begin
                next_result = {fval[caas_pkg::MSB], fval[7:1]}; // RULE_08
                next_carry_src = {7'h00, fval[0]}; // RULE_09
                next_wr_file = (dest_in == caas_pkg::DEST_FILE); // RULE_07
                next_wr_acc = (dest_in == caas_pkg::DEST_ACC); // RULE_07
                upd_z = 1'b1;
                upd_c = 1'b1; // digit carry left alone
            end
            caas_pkg::CAAS_OP_CLR_BIT: begin
                next_result = fval & ~(8'h01 << bit_idx_in); // RULE_12
                next_wr_file = 1'b1;
            end
            default: begin
                next_result = 8'h00; // pointer add and idle write no byte
            end
        endcase
    end

    // accumulator update
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            acc <= caas_pkg::ACC_RESET;
        end else if (exec_in && next_wr_acc) begin
            acc <= next_result;
        end
    end

    // pointer pairs; only the selected one changes
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ptr[0] <= caas_pkg::PTR_RESET;
            ptr[1] <= caas_pkg::PTR_RESET;
        end else if (exec_in && op_in == caas_pkg::CAAS_OP_PTR_ADD) begin
            ptr[ptr_sel_in] <= next_ptr; // RULE_01
        end
    end

    // file registers, reset to zero so reads are never unknown
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= caas_pkg::FILE_RESET;
            end
        end else if (exec_in && next_wr_file) begin
            mem[file_addr_in] <= next_result; // RULE_07 RULE_11
        end
    end

    // status flags; ops that do not name a flag leave it as is
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            carry <= caas_pkg::FLAG_RESET;
            dcarry <= caas_pkg::FLAG_RESET;
            zero <= caas_pkg::FLAG_RESET;
        end else if (exec_in) begin
            if (upd_z) begin
                zero <= (next_result == 8'h00); // RULE_13
            end
            if (upd_c) begin
                if (op_in == caas_pkg::CAAS_OP_ASR_FILE) begin
                    carry <= next_carry_src[0]; // RULE_09
                end else begin
                    carry <= add_co; // RULE_13
                end
            end
            if (upd_dc) begin
                dcarry <= add_dc; // RULE_13
            end
        end
    end

    // registered read port shows the addressed file register
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            file_rd <= caas_pkg::FILE_RESET;
        end else begin
            file_rd <= fval;
        end
    end

    assign acc_out = acc;
    assign pointer0_out = ptr[0];
    assign pointer1_out = ptr[1];
    assign carry_flag_out = carry;
    assign digit_carry_flag_out = dcarry;
    assign zero_flag_out = zero;
    assign file_rd_out = file_rd;
endmodule : caas_alu

// [design/caas_pkg.sv]
// constants and operation codes for the add and shift execution datapath
package caas_pkg;
    localparam int DATA_W = 8; // data path width
    localparam int PTR_W = 16; // indirect pointer width
    localparam int ADDR_W = 7; // file register address width
    localparam int LIT6_W = 6; // pointer literal width
    localparam int BIT_IDX_W = 3; // bit index width
    localparam int DC_BIT = 4; // sum bit that holds carry out of bit 3
    localparam int MSB = 7; // sign bit position
    localparam logic [7:0] ACC_RESET = 8'h00; // accumulator reset value
    localparam logic [15:0] PTR_RESET = 16'h0000; // pointer reset value
    localparam logic [7:0] FILE_RESET = 8'h00; // file memory reset value
    localparam logic FLAG_RESET = 1'b0; // status flag reset value
    localparam logic DEST_ACC = 1'b0; // destination bit: accumulator
    localparam logic DEST_FILE = 1'b1; // destination bit: file register

    // operation select
    typedef enum logic [3:0] {
        CAAS_OP_NONE,
        CAAS_OP_PTR_ADD,
        CAAS_OP_AND_LIT,
        CAAS_OP_ADD_LIT,
        CAAS_OP_AND_FILE,
        CAAS_OP_ADD_FILE,
        CAAS_OP_ASR_FILE,
        CAAS_OP_ADD_FILE_C,
        CAAS_OP_CLR_BIT
    } caas_op_t;
endpackage : caas_pkg

// [design/caas_adder.sv]
// eight-bit adder with carry in, carry out and digit carry
module caas_adder (
    input wire logic [7:0] a_in, // first operand
    input wire logic [7:0] b_in, // second operand
    input wire logic c_in, // carry in
    output logic [7:0] sum_out, // 8-bit sum
    output logic c_out, // carry out of bit 7
    output logic dc_out // carry out of bit 3
);
    logic [8:0] full; // sum with carry column
    logic [4:0] low; // low nibble sum with carry column

    // nibble sum computed apart so digit carry needs no reverse engineering
    always_comb begin
        full = {1'b0, a_in} + {1'b0, b_in} + {8'h00, c_in};
        low = {1'b0, a_in[3:0]} + {1'b0, b_in[3:0]} + {4'h0, c_in};
        sum_out = full[7:0];
        c_out = full[8];
        dc_out = low[caas_pkg::DC_BIT];
    end
endmodule : caas_adder

// [verification/caas_alu_monitor.sv]
// port-level checker for the add and shift execution datapath
module caas_alu_monitor (
    input wire logic core_clk_in, // clock
    input wire logic rst_b_in, // reset, active low
    input wire logic exec_in, // strobe
    input wire caas_pkg::caas_op_t op_in, // op
    input wire logic [7:0] literal_in, // literal
    input wire logic [5:0] ptr_lit_in, // pointer literal
    input wire logic ptr_sel_in, // pointer select
    input wire logic dest_in, // destination
    input wire logic [7:0] acc_out, // accumulator
    input wire logic [15:0] pointer0_out, // pointer 0
    input wire logic [15:0] pointer1_out, // pointer 1
    input wire logic carry_flag_out, // carry
    input wire logic digit_carry_flag_out, // digit carry
    input wire logic zero_flag_out // zero
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rst_b_in);
    wire logic [2:0] flags = {carry_flag_out, digit_carry_flag_out, zero_flag_out}; // all flags
    wire logic [4:0] nib = {1'b0, acc_out[3:0]} + {1'b0, literal_in[3:0]}; // low nibble sum
    wire logic [15:0] sext = {{10{ptr_lit_in[5]}}, ptr_lit_in}; // literal, sign kept
    wire logic ptr_go = exec_in && op_in == caas_pkg::CAAS_OP_PTR_ADD; // pointer op taken
    // file ops whose result goes back to the file, not the accumulator
    wire logic to_file = exec_in && dest_in == caas_pkg::DEST_FILE
        && op_in >= caas_pkg::CAAS_OP_AND_FILE && op_in <= caas_pkg::CAAS_OP_ADD_FILE_C;
    a_ptr0_sum:
        assert property (ptr_go && !ptr_sel_in |=> pointer0_out == $past(pointer0_out) + $past(sext))
        else $error("pointer 0 sum wrong");
    a_ptr1_sum:
        assert property (ptr_go && ptr_sel_in |=> pointer1_out == $past(pointer1_out) + $past(sext))
        else $error("pointer 1 sum wrong");
    a_ptr_flags_kept:
        assert property (ptr_go |=> $stable(flags) && $stable(acc_out))
        else $error("pointer add touched flags");
    a_and_lit_zero:
        assert property (exec_in && op_in == caas_pkg::CAAS_OP_AND_LIT |=>
            acc_out == ($past(acc_out) & $past(literal_in)) && zero_flag_out == (acc_out == 8'h00)
            && $stable(flags[2:1])) else $error("and literal wrong");
    a_add_lit_sum:
        assert property (exec_in && op_in == caas_pkg::CAAS_OP_ADD_LIT |=>
            {carry_flag_out, acc_out} == {1'b0, $past(acc_out)} + {1'b0, $past(literal_in)}
            && digit_carry_flag_out == $past(nib[4]) && zero_flag_out == (acc_out == 8'h00))
        else $error("add literal wrong");
    a_file_dest_acc:
        assert property (to_file |=> $stable(acc_out)) else $error("file dest wrote accumulator");
    a_clr_bit_quiet:
        assert property (exec_in && op_in == caas_pkg::CAAS_OP_CLR_BIT |=> $stable(flags)
            && $stable(acc_out)) else $error("bit clear touched flags");
    a_asr_dc_kept:
        assert property (exec_in && op_in == caas_pkg::CAAS_OP_ASR_FILE |=>
            $stable(digit_carry_flag_out)) else $error("shift touched digit carry");
    c_file_write: cover property (to_file);
    c_carry_zero: cover property (carry_flag_out && zero_flag_out);
    c_ptr_add: cover property (ptr_go ##1 pointer0_out == 16'h0000);
endmodule : caas_alu_monitor

bind caas_alu caas_alu_monitor caas_alu_monitor_i (.core_clk_in, .rst_b_in, .exec_in, .op_in,
    .literal_in, .ptr_lit_in, .ptr_sel_in, .dest_in, .acc_out, .pointer0_out, .pointer1_out,
    .carry_flag_out, .digit_carry_flag_out, .zero_flag_out);

// [verification/caas_alu_bench.sv]
// self-checking bench for the add and shift execution datapath
module caas_alu_bench;
    timeunit 1ns;
    timeprecision 100ps;
    // op code, shared operand, dest, expected accumulator and {c, dc, z}
    typedef struct {logic [3:0] op; logic [7:0] a; logic d; logic [7:0] acc; logic [2:0] f;} caas_row_t;
    localparam int N = 25; // row count
    logic core_clk_in = 1'b0; // clock
    logic rst_b_in = 1'b0; // reset, held at start
    logic exec_in = 1'b0; // strobe
    caas_pkg::caas_op_t op_in = caas_pkg::CAAS_OP_NONE; // op
    logic [7:0] opnd = 8'h00; // literal, address and pointer literal share one bus
    logic dest_in = 1'b0; // destination, also pointer select
    logic [2:0] bit_idx_in = 3'h0; // bit index
    logic [7:0] acc_out, file_rd_out; // data results
    logic [15:0] p0, p1; // pointers
    logic c, dc, z; // flags
    wire logic [2:0] flags = {c, dc, z}; // grouped flags
    int n_mismatch = 0;
    int samples_checked = 0;
    // file data is only reachable through ops, so rows build it up in order
    caas_row_t rows [N] = '{
        '{4'h3, 8'h8F, 1'h0, 8'h8F, 3'h0}, '{4'h3, 8'h81, 1'h0, 8'h10, 3'h6},
        '{4'h5, 8'h05, 1'h1, 8'h10, 3'h0}, '{4'h7, 8'h05, 1'h0, 8'h20, 3'h0},
        '{4'h2, 8'h0F, 1'h0, 8'h00, 3'h1}, '{4'h3, 8'hFF, 1'h0, 8'hFF, 3'h0},
        '{4'h3, 8'h01, 1'h0, 8'h00, 3'h7}, '{4'h7, 8'h05, 1'h1, 8'h00, 3'h0},
        '{4'h3, 8'h80, 1'h0, 8'h80, 3'h0}, '{4'h5, 8'h05, 1'h0, 8'h91, 3'h0},
        '{4'h5, 8'h06, 1'h1, 8'h91, 3'h0}, '{4'h6, 8'h06, 1'h0, 8'hC8, 3'h4},
        '{4'h6, 8'h06, 1'h1, 8'hC8, 3'h4}, '{4'h4, 8'h06, 1'h0, 8'hC8, 3'h4},
        '{4'h6, 8'h06, 1'h0, 8'hE4, 3'h0}, '{4'h2, 8'h00, 1'h0, 8'h00, 3'h1},
        '{4'h4, 8'h06, 1'h1, 8'h00, 3'h1}, '{4'h5, 8'h06, 1'h0, 8'h00, 3'h1},
        '{4'h1, 8'h20, 1'h0, 8'h00, 3'h1}, '{4'h1, 8'h1F, 1'h1, 8'h00, 3'h1},
        '{4'h1, 8'h01, 1'h0, 8'h00, 3'h1}, '{4'h1, 8'h1F, 1'h0, 8'h00, 3'h1},
        '{4'h3, 8'hFF, 1'h0, 8'hFF, 3'h0}, '{4'h5, 8'h07, 1'h1, 8'hFF, 3'h0},
        '{4'h0, 8'h00, 1'h0, 8'hFF, 3'h0}};
    caas_alu caas_alu_i (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .exec_in(exec_in),
        .op_in(op_in), .literal_in(opnd), .ptr_lit_in(opnd[5:0]), .ptr_sel_in(dest_in),
        .file_addr_in(opnd[6:0]), .dest_in(dest_in), .bit_idx_in(bit_idx_in), .acc_out(acc_out),
        .pointer0_out(p0), .pointer1_out(p1), .carry_flag_out(c), .digit_carry_flag_out(dc),
        .zero_flag_out(z), .file_rd_out(file_rd_out));
    always #25 core_clk_in = ~core_clk_in;
    // one compare for every result; narrow values are zero-extended
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic tally_and_finish();
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : tally_and_finish
    // a hang ends the run at 1000 cycles, well after the roughly 60 cycles needed
    initial begin
        repeat (1000) @(posedge core_clk_in);
        n_mismatch++;
        tally_and_finish();
    end
    initial begin
        repeat (8) @(posedge core_clk_in);
        rst_b_in <= 1'b1;
        // rows back to back; row i-1 is checked while row i is offered
        for (int i = 0; i <= N; i++) begin
            @(posedge core_clk_in);
            exec_in <= (i < N);
            if (i < N) begin
                op_in <= caas_pkg::caas_op_t'(rows[i].op);
                opnd <= rows[i].a;
                dest_in <= rows[i].d;
            end
            @(negedge core_clk_in);
            if (i > 0) begin
                chk({8'h00, acc_out}, {8'h00, rows[i-1].acc});
                chk({13'h0000, flags}, {13'h0000, rows[i-1].f});
            end
        end
        chk(p0, 16'h0000);
        chk(p1, 16'h001F);
        // clear each bit of file 7 in turn; readback lags by one edge
        for (int b = 0; b < 8; b++) begin
            @(posedge core_clk_in);
            exec_in <= 1'b1;
            op_in <= caas_pkg::CAAS_OP_CLR_BIT;
            opnd <= 8'h07;
            bit_idx_in <= b[2:0];
            @(posedge core_clk_in);
            exec_in <= 1'b0;
            @(negedge core_clk_in);
            chk({13'h0000, flags}, 16'h0000);
            @(negedge core_clk_in);
            chk(file_rd_out, {8'h00, 8'hFF << (b + 1)});
        end
        // reset in mid-run clears outputs and the file
        @(posedge core_clk_in);
        rst_b_in <= 1'b0;
        op_in <= caas_pkg::CAAS_OP_ADD_FILE;
        @(negedge core_clk_in);
        chk({8'h00, acc_out}, 16'h0000);
        chk(p1, 16'h0000);
        @(posedge core_clk_in);
        rst_b_in <= 1'b1;
        exec_in <= 1'b1;
        opnd <= 8'h05;
        @(posedge core_clk_in);
        exec_in <= 1'b0;
        @(negedge core_clk_in);
        // file 5 held 8'h11 before reset; a zero sum shows the file was cleared
        chk({13'h0000, flags}, 16'h0001);
        tally_and_finish();
    end
endmodule : caas_alu_bench
